/* rtl/acu_regs.sv */
// Register bank: generation id, second converter path results, charger control, USB id control.
// Assumes the serial interface presents decoded word accesses on this clock, one per cycle at most.
`timescale 1ns/100ps

// How it works
// RL1 - Bits 6 to 8 of the id register read a fixed three-bit generation code untouched by reset.
// RL2 - The first channel result of the second converter path reads in bits 2 to 11 of the result register.
// RL3 - The second channel result of the second converter path reads in bits 14 to 23 of the result register.
// RL4 - The three-bit charge voltage in charger bits 0 to 2 is host writable and resets to three.
// RL5 - The four-bit charge current in charger bits 3 to 6 resets to zero and both host and device may change it.
// RL6 - Charger bit 7 turns on trickle current, host writable, reset low.
// RL7 - Charger bit 9 disables the thermistor check, host writable, reset low so the check runs.
// RL8 - Charger bit 20 written high restarts the charger state machine, the device may clear it, reset low.
// RL9 - Charger bit 21 blocks automatic charging while on, reset low.
// RL10 - Charger bit 23 lets the host program voltage and current, reset low, and bit 22 resets high.
// RL11 - USB bit 22 selects the id pull-up source, reset low, and USB bit 6 is a spare reset high.
// RL12 - Unused and reserved bits always read zero and ignore writes.
module acu_regs
    import acu_pkg::*;
#(
    parameter logic [2:0] GEN_ID = ACU_GEN_ID_DFLT   // Arbitrary value
) (
    input  wire logic                  clock,
    input  wire logic                  srst,
    input  wire logic [ACU_ADDR_W-1:0] reg_addr,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    input  wire logic [ACU_DATA_W-1:0] reg_wdata,
    output logic      [ACU_DATA_W-1:0] reg_rdata_reg,
    output logic                       reg_rvalid_reg,
    input  wire logic                  result_valid,
    input  wire logic [ACU_RES_W-1:0]  result_one,
    input  wire logic [ACU_RES_W-1:0]  result_two,
    input  wire logic                  dev_current_wr,
    input  wire logic [ACU_CUR_W-1:0]  dev_current_val,
    input  wire logic                  dev_restart_clr,
    input  wire logic                  dev_timer_rst_clr,
    input  wire logic                  dev_reverse_clr,
    output logic      [ACU_VOLT_W-1:0] charge_voltage_reg,
    output logic      [ACU_CUR_W-1:0]  charge_current_reg,
    output logic                       trickle_enable_reg,
    output logic                       low_power_boot_ack_reg,
    output logic                       thermistor_check_disable_reg,
    output logic                       battery_switch_override_reg,
    output logic                       battery_switch_ctrl_reg,
    output logic                       charger_spare_reg,
    output logic                       reverse_mode_reg,
    output logic      [ACU_PLIM_W-1:0] power_limit_reg,
    output logic                       power_limit_disable_reg,
    output logic                       charge_led_enable_reg,
    output logic                       charge_timer_reset_reg,
    output logic                       charger_fsm_restart_reg,
    output logic                       auto_charge_block_reg,
    output logic                       cycling_disable_reg,
    output logic                       vi_program_allow_reg,
    output logic                       usb_spare_reg,
    output logic                       id_pullup_source_sel_reg
);

    ////////////////////////////////////////////////////////////////////////////////
    // Decode

    function automatic logic acu_hit(input logic [ACU_ADDR_W-1:0] addr, input logic [ACU_ADDR_W-1:0] off);
        acu_hit = (addr == off);
    endfunction : acu_hit

    logic                 wr_charger;
    logic                 wr_usb;
    logic                 vi_write_ok;
    logic [ACU_RES_W-1:0] held_one_reg;
    logic [ACU_RES_W-1:0] held_two_reg;
    logic [ACU_DATA_W-1:0] rdata_next;

    assign wr_charger  = reg_wr && acu_hit(reg_addr, ACU_OFF_CHARGER);
    assign wr_usb      = reg_wr && acu_hit(reg_addr, ACU_OFF_USB);
    // The permit travels in the same word, so one write can unlock and program together
    assign vi_write_ok = wr_charger && reg_wdata[ACU_VI_ALLOW];                     // RL10

    ////////////////////////////////////////////////////////////////////////////////
    // Converter results

    acu_result_hold #(
        .W (ACU_RES_W)
    ) u_results (
        .clock        (clock),
        .srst         (srst),
        .sample_valid (result_valid),
        .sample_one   (result_one),
        .sample_two   (result_two),
        .held_one_reg (held_one_reg),
        .held_two_reg (held_two_reg)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Fields the device may also change

    acu_rwm_field #(
        .W         (ACU_CUR_W),
        .RESET_VAL (ACU_CUR_RST),
        .DEV_WINS  (1'b1)
    ) u_current (                                                                   // RL5
        .clock    (clock),
        .srst     (srst),
        .host_wr  (vi_write_ok),
        .host_val (reg_wdata[ACU_CUR_LSB +: ACU_CUR_W]),
        .dev_wr   (dev_current_wr),
        .dev_val  (dev_current_val),
        .q_reg    (charge_current_reg)
    );

    // A host restart request is not lost to a device clear in the same cycle
    acu_rwm_field #(
        .W         (1),
        .RESET_VAL (1'b0),
        .DEV_WINS  (1'b0)
    ) u_restart (                                                                   // RL8
        .clock    (clock),
        .srst     (srst),
        .host_wr  (wr_charger),
        .host_val (reg_wdata[ACU_RESTART]),
        .dev_wr   (dev_restart_clr),
        .dev_val  (1'b0),
        .q_reg    (charger_fsm_restart_reg)
    );

    acu_rwm_field #(
        .W         (1),
        .RESET_VAL (1'b0),
        .DEV_WINS  (1'b0)
    ) u_timer_rst (
        .clock    (clock),
        .srst     (srst),
        .host_wr  (wr_charger),
        .host_val (reg_wdata[ACU_TMR_RST]),
        .dev_wr   (dev_timer_rst_clr),
        .dev_val  (1'b0),
        .q_reg    (charge_timer_reset_reg)
    );

    acu_rwm_field #(
        .W         (1),
        .RESET_VAL (1'b0),
        .DEV_WINS  (1'b0)
    ) u_reverse (
        .clock    (clock),
        .srst     (srst),
        .host_wr  (wr_charger),
        .host_val (reg_wdata[ACU_REVERSE]),
        .dev_wr   (dev_reverse_clr),
        .dev_val  (1'b0),
        .q_reg    (reverse_mode_reg)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Host-only charger fields

    always_ff @(posedge clock) begin
        if (srst) begin
            charge_voltage_reg <= ACU_VOLT_RST;                                     // RL4
        end else if (vi_write_ok) begin
            charge_voltage_reg <= reg_wdata[ACU_VOLT_LSB +: ACU_VOLT_W];            // RL4
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            trickle_enable_reg           <= 1'b0;
            low_power_boot_ack_reg       <= 1'b0;
            thermistor_check_disable_reg <= 1'b0;
            battery_switch_override_reg  <= 1'b0;
            battery_switch_ctrl_reg      <= 1'b0;
            charger_spare_reg            <= 1'b0;
            power_limit_reg              <= '0;
            power_limit_disable_reg      <= 1'b0;
            charge_led_enable_reg        <= 1'b0;
            auto_charge_block_reg        <= 1'b0;
            cycling_disable_reg          <= ACU_CYCLE_RST;                          // RL10
            vi_program_allow_reg         <= 1'b0;
        end else if (wr_charger) begin
            trickle_enable_reg           <= reg_wdata[ACU_TRICKLE];                 // RL6
            low_power_boot_ack_reg       <= reg_wdata[ACU_ACK_LPB];
            thermistor_check_disable_reg <= reg_wdata[ACU_THERM_DIS];               // RL7
            battery_switch_override_reg  <= reg_wdata[ACU_FET_OVR];
            battery_switch_ctrl_reg      <= reg_wdata[ACU_FET_CTRL];
            charger_spare_reg            <= reg_wdata[ACU_CHG_SPARE];
            power_limit_reg              <= reg_wdata[ACU_PLIM_LSB +: ACU_PLIM_W];
            power_limit_disable_reg      <= reg_wdata[ACU_PLIM_DIS];
            charge_led_enable_reg        <= reg_wdata[ACU_LED_EN];
            auto_charge_block_reg        <= reg_wdata[ACU_AUTO_BLOCK];              // RL9
            cycling_disable_reg          <= reg_wdata[ACU_CYCLE_DIS];
            vi_program_allow_reg         <= reg_wdata[ACU_VI_ALLOW];                // RL10
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // USB identification control

    always_ff @(posedge clock) begin
        if (srst) begin
            usb_spare_reg            <= ACU_USB_SPARE_RST;                          // RL11
            id_pullup_source_sel_reg <= 1'b0;
        end else if (wr_usb) begin
            usb_spare_reg            <= reg_wdata[ACU_USB_SPARE];                   // RL11
            id_pullup_source_sel_reg <= reg_wdata[ACU_USB_ID_SEL];                  // RL11
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read path: only named fields are placed, every other bit stays zero

    always_comb begin
        rdata_next = '0;                                                            // RL12
        unique case (1'b1)
            acu_hit(reg_addr, ACU_OFF_GEN_ID): begin
                rdata_next[ACU_GEN_ID_LSB +: ACU_GEN_ID_W] = GEN_ID;                // RL1
            end
            acu_hit(reg_addr, ACU_OFF_RESULTS): begin
                rdata_next[ACU_RES_ONE_LSB +: ACU_RES_W] = held_one_reg;            // RL2
                rdata_next[ACU_RES_TWO_LSB +: ACU_RES_W] = held_two_reg;            // RL3
            end
            acu_hit(reg_addr, ACU_OFF_CHARGER): begin
                rdata_next[ACU_VOLT_LSB +: ACU_VOLT_W] = charge_voltage_reg;
                rdata_next[ACU_CUR_LSB +: ACU_CUR_W]   = charge_current_reg;
                rdata_next[ACU_TRICKLE]                = trickle_enable_reg;
                rdata_next[ACU_ACK_LPB]                = low_power_boot_ack_reg;
                rdata_next[ACU_THERM_DIS]              = thermistor_check_disable_reg;
                rdata_next[ACU_FET_OVR]                = battery_switch_override_reg;
                rdata_next[ACU_FET_CTRL]               = battery_switch_ctrl_reg;
                rdata_next[ACU_CHG_SPARE]              = charger_spare_reg;
                rdata_next[ACU_REVERSE]                = reverse_mode_reg;
                rdata_next[ACU_PLIM_LSB +: ACU_PLIM_W] = power_limit_reg;
                rdata_next[ACU_PLIM_DIS]               = power_limit_disable_reg;
                rdata_next[ACU_LED_EN]                 = charge_led_enable_reg;
                rdata_next[ACU_TMR_RST]                = charge_timer_reset_reg;
                rdata_next[ACU_RESTART]                = charger_fsm_restart_reg;
                rdata_next[ACU_AUTO_BLOCK]             = auto_charge_block_reg;
                rdata_next[ACU_CYCLE_DIS]              = cycling_disable_reg;
                rdata_next[ACU_VI_ALLOW]               = vi_program_allow_reg;
            end
            acu_hit(reg_addr, ACU_OFF_USB): begin
                rdata_next[ACU_USB_SPARE]  = usb_spare_reg;
                rdata_next[ACU_USB_ID_SEL] = id_pullup_source_sel_reg;
            end
            default: begin
                rdata_next = '0;
            end
        endcase
    end

    // Read data holds until the next read so a slow serial shifter can take it
    always_ff @(posedge clock) begin
        if (srst) begin
            reg_rdata_reg <= '0;
        end else if (reg_rd) begin
            reg_rdata_reg <= rdata_next;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            reg_rvalid_reg <= 1'b0;
        end else begin
            reg_rvalid_reg <= reg_rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    sequence s_read(logic [ACU_ADDR_W-1:0] off);
        reg_rd && reg_addr == off;
    endsequence

    sequence s_chg_write;
        reg_wr && reg_addr == ACU_OFF_CHARGER;
    endsequence

    a_gen_id_read: assert property (                                                // RL1
        s_read(ACU_OFF_GEN_ID) |=> reg_rvalid_reg && reg_rdata_reg == ({21'h0, GEN_ID} << ACU_GEN_ID_LSB))
        else $error("generation id read wrong");

    a_result_one_read: assert property (                                            // RL2
        result_valid ##1 (s_read(ACU_OFF_RESULTS) and !result_valid)
        |=> reg_rdata_reg[11:2] == $past(result_one, 2) && reg_rdata_reg[1:0] == 2'h0)
        else $error("first channel result not presented");

    a_result_two_read: assert property (                                            // RL3
        result_valid ##1 (s_read(ACU_OFF_RESULTS) and !result_valid)
        |=> reg_rdata_reg[23:14] == $past(result_two, 2) && reg_rdata_reg[13:12] == 2'h0)
        else $error("second channel result not presented");

    a_volt_reset_val: assert property (                                             // RL4
        $past(srst) |-> charge_voltage_reg == 3'h3 && cycling_disable_reg && !vi_program_allow_reg)
        else $error("charger defaults wrong after reset");

    a_volt_gated_write: assert property (                                           // RL10
        (s_chg_write and !reg_wdata[ACU_VI_ALLOW]) |=> $stable(charge_voltage_reg))
        else $error("voltage changed without permit");

    a_current_dev_mod: assert property (                                            // RL5
        dev_current_wr |=> charge_current_reg == $past(dev_current_val))
        else $error("device current update lost");

    a_trickle_therm_wr: assert property (                                           // RL6
        s_chg_write |=> trickle_enable_reg == $past(reg_wdata[7]) &&
                        thermistor_check_disable_reg == $past(reg_wdata[9]))
        else $error("trickle or thermistor bit not written");

    a_restart_set_clr: assert property (                                            // RL8
        (s_chg_write and reg_wdata[ACU_RESTART]) ##1 (dev_restart_clr && !reg_wr)
        |-> charger_fsm_restart_reg ##1 !charger_fsm_restart_reg)
        else $error("restart bit sequence wrong");

    a_auto_block_wr: assert property (                                              // RL9
        s_chg_write |=> auto_charge_block_reg == $past(reg_wdata[21]))
        else $error("auto charge block not written");

    a_usb_sel_wr: assert property (                                                 // RL11
        reg_wr && reg_addr == ACU_OFF_USB |=> id_pullup_source_sel_reg == $past(reg_wdata[22]) &&
                                              usb_spare_reg == $past(reg_wdata[6]))
        else $error("usb control not written");

    a_reserved_zero: assert property (                                              // RL12
        s_read(ACU_OFF_USB) |=> (reg_rdata_reg & 24'hbfffbf) == 24'h0)
        else $error("reserved usb bits read nonzero");

    a_unmapped_zero: assert property (                                              // RL12
        reg_rd && (reg_addr < ACU_OFF_GEN_ID || reg_addr > ACU_OFF_USB) |=> reg_rdata_reg == 24'h0)
        else $error("unmapped read nonzero");

endmodule : acu_regs

/* rtl/acu_pkg.sv */
// Constants of the converter result, charger and USB identification register bank.
// Assumes a 24-bit register word and a 6-bit register index from the serial register port.
package acu_pkg;

    localparam int          ACU_ADDR_W       = 6;
    localparam int          ACU_DATA_W       = 24;
    localparam int          ACU_RES_W        = 10;
    localparam int          ACU_RD_LATENCY   = 1;

    ////////////////////////////////////////////////////////////////////////////////
    // Register indexes
    localparam logic [5:0]  ACU_OFF_GEN_ID   = 6'h2e;
    localparam logic [5:0]  ACU_OFF_RESULTS  = 6'h2f;
    localparam logic [5:0]  ACU_OFF_CHARGER  = 6'h30;
    localparam logic [5:0]  ACU_OFF_USB      = 6'h31;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int          ACU_GEN_ID_LSB   = 6;
    localparam int          ACU_GEN_ID_W     = 3;
    localparam int          ACU_RES_ONE_LSB  = 2;
    localparam int          ACU_RES_TWO_LSB  = 14;
    localparam int          ACU_VOLT_LSB     = 0;
    localparam int          ACU_VOLT_W       = 3;
    localparam int          ACU_CUR_LSB      = 3;
    localparam int          ACU_CUR_W        = 4;
    localparam int          ACU_TRICKLE      = 7;
    localparam int          ACU_ACK_LPB      = 8;
    localparam int          ACU_THERM_DIS    = 9;
    localparam int          ACU_FET_OVR      = 10;
    localparam int          ACU_FET_CTRL     = 11;
    localparam int          ACU_CHG_SPARE    = 12;
    localparam int          ACU_REVERSE      = 13;
    localparam int          ACU_PLIM_LSB     = 15;
    localparam int          ACU_PLIM_W       = 2;
    localparam int          ACU_PLIM_DIS     = 17;
    localparam int          ACU_LED_EN       = 18;
    localparam int          ACU_TMR_RST      = 19;
    localparam int          ACU_RESTART      = 20;
    localparam int          ACU_AUTO_BLOCK   = 21;
    localparam int          ACU_CYCLE_DIS    = 22;
    localparam int          ACU_VI_ALLOW     = 23;
    localparam int          ACU_USB_SPARE    = 6;
    localparam int          ACU_USB_ID_SEL   = 22;

    ////////////////////////////////////////////////////////////////////////////////
    // Values after reset
    localparam logic [2:0]  ACU_VOLT_RST     = 3'h3;
    localparam logic [3:0]  ACU_CUR_RST      = 4'h0;
    localparam logic        ACU_CYCLE_RST    = 1'h1;
    localparam logic        ACU_USB_SPARE_RST = 1'h1;
    localparam logic [2:0]  ACU_GEN_ID_DFLT  = 3'h5;   // Arbitrary value

endpackage : acu_pkg

/* rtl/acu_rwm_field.sv */
// Register field written by the host and also modified by device logic.
// Assumes both writers are on the same clock as the field.
`timescale 1ns/100ps
module acu_rwm_field
    import acu_pkg::*;
#(
    parameter int            W         = 1,
    parameter logic [W-1:0]  RESET_VAL = '0,
    parameter bit            DEV_WINS  = 1'b1
) (
    input  wire logic         clock,
    input  wire logic         srst,
    input  wire logic         host_wr,
    input  wire logic [W-1:0] host_val,
    input  wire logic         dev_wr,
    input  wire logic [W-1:0] dev_val,
    output logic      [W-1:0] q_reg
);

    generate
        if (W < 1) begin : g_bad_width
            $error("acu_rwm_field: width must be at least one");
        end
    endgenerate

    // DEV_WINS picks the writer whose value is kept when both act in one cycle
    always_ff @(posedge clock) begin
        if (srst) begin
            q_reg <= RESET_VAL;
        end else if (dev_wr && (DEV_WINS || !host_wr)) begin
            q_reg <= dev_val;
        end else if (host_wr) begin
            q_reg <= host_val;
        end
    end

endmodule : acu_rwm_field

/* rtl/acu_result_hold.sv */
// Holding registers for the two channel results of the second converter path.
// Assumes the converter logic runs on this clock and marks a finished pair with a one-cycle strobe.
`timescale 1ns/100ps
module acu_result_hold
    import acu_pkg::*;
#(
    parameter int W = ACU_RES_W
) (
    input  wire logic         clock,
    input  wire logic         srst,
    input  wire logic         sample_valid,
    input  wire logic [W-1:0] sample_one,
    input  wire logic [W-1:0] sample_two,
    output logic      [W-1:0] held_one_reg,
    output logic      [W-1:0] held_two_reg
);

    generate
        if (W < 1 || W > ACU_RES_W) begin : g_bad_width
            $error("acu_result_hold: width out of range");
        end
    endgenerate

    // Both channels update together so a read never mixes two conversions
    always_ff @(posedge clock) begin
        if (srst) begin
            held_one_reg <= '0;
            held_two_reg <= '0;
        end else if (sample_valid) begin
            held_one_reg <= sample_one;
            held_two_reg <= sample_two;
        end
    end

endmodule : acu_result_hold

/* bench/tb_top.sv */
// Self-checking bench for the converter result, charger and USB id register bank.
// Assumes the rtl package and modules compile first; all inputs change on the falling clock edge.
`timescale 1ns/100ps
module tb_top;
    import acu_pkg::*;
    localparam logic [2:0] GEN_ID = 3'h2;   // Arbitrary value
    logic                  clock = 1'b0;
    logic                  srst = 1'b1;
    logic [ACU_ADDR_W-1:0] reg_addr = '0;
    logic                  reg_wr = 1'b0;
    logic                  reg_rd = 1'b0;
    logic [ACU_DATA_W-1:0] reg_wdata = '0;
    logic [ACU_DATA_W-1:0] reg_rdata_reg;
    logic                  reg_rvalid_reg;
    logic                  result_valid = 1'b0;
    logic [ACU_RES_W-1:0]  result_one = 10'h3a5;
    logic [ACU_RES_W-1:0]  result_two = 10'h25a;
    logic                  dev_current_wr = 1'b0;
    logic [ACU_CUR_W-1:0]  dev_current_val = 4'h9;
    logic                  dev_restart_clr = 1'b0;
    logic                  dev_timer_rst_clr = 1'b0;
    logic                  dev_reverse_clr = 1'b0;
    wire  [ACU_DATA_W-1:0] chg_pins;
    wire  [1:0]            usb_pins;
    int                    bad_count = 0;
    int                    check_count = 0;

    always #4 clock = ~clock;

    // Reserved place of the charger word, no pin behind it
    assign chg_pins[14] = 1'b0;

    acu_regs #(.GEN_ID(GEN_ID)) acu_regs_i (
        .clock, .srst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_reg, .reg_rvalid_reg,
        .result_valid, .result_one, .result_two, .dev_current_wr, .dev_current_val,
        .dev_restart_clr, .dev_timer_rst_clr, .dev_reverse_clr, .charge_voltage_reg(chg_pins[2:0]),
        .charge_current_reg(chg_pins[6:3]), .trickle_enable_reg(chg_pins[7]), .low_power_boot_ack_reg(chg_pins[8]),
        .thermistor_check_disable_reg(chg_pins[9]), .battery_switch_override_reg(chg_pins[10]),
        .battery_switch_ctrl_reg(chg_pins[11]), .charger_spare_reg(chg_pins[12]), .reverse_mode_reg(chg_pins[13]),
        .power_limit_reg(chg_pins[16:15]), .power_limit_disable_reg(chg_pins[17]),
        .charge_led_enable_reg(chg_pins[18]), .charge_timer_reset_reg(chg_pins[19]),
        .charger_fsm_restart_reg(chg_pins[20]), .auto_charge_block_reg(chg_pins[21]),
        .cycling_disable_reg(chg_pins[22]), .vi_program_allow_reg(chg_pins[23]), .usb_spare_reg(usb_pins[0]),
        .id_pullup_source_sel_reg(usb_pins[1])
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [ACU_DATA_W-1:0] exp, input logic [ACU_DATA_W-1:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr_reg(input logic [ACU_ADDR_W-1:0] a, input logic [ACU_DATA_W-1:0] d);
        @(negedge clock);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clock);
        reg_wr    = 1'b0;
    endtask : wr_reg

    // Answer lands one cycle after the strobe, so it is settled by the next falling edge
    task automatic rd_chk(input logic [ACU_ADDR_W-1:0] a, input logic [ACU_DATA_W-1:0] exp);
        @(negedge clock);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge clock);
        reg_rd   = 1'b0;
        chk("read valid", 24'h000001, {23'h0, reg_rvalid_reg});
        chk($sformatf("register %h", a), exp, reg_rdata_reg);
    endtask : rd_chk

    task automatic dev_pulse(input logic cur, input logic rst, input logic tmr, input logic rev);
        @(negedge clock);
        {dev_current_wr, dev_restart_clr, dev_timer_rst_clr, dev_reverse_clr} = {cur, rst, tmr, rev};
        @(negedge clock);
        {dev_current_wr, dev_restart_clr, dev_timer_rst_clr, dev_reverse_clr} = 4'h0;
    endtask : dev_pulse

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd_chk(ACU_OFF_CHARGER, 24'h400003);
        rd_chk(ACU_OFF_USB, 24'h000040);
        rd_chk(ACU_OFF_GEN_ID, {15'h0, GEN_ID, 6'h00});
        chk("charger pins", 24'h400003, chg_pins);
        chk("usb pins", 24'h000001, {22'h0, usb_pins});
    endtask : t_reset

    // Reserved bit 14 stays zero; without the permit bit voltage and current hold
    task automatic t_charger;
        wr_reg(ACU_OFF_CHARGER, 24'hffffff);
        rd_chk(ACU_OFF_CHARGER, 24'hffbfff);
        wr_reg(ACU_OFF_CHARGER, 24'h000000);
        rd_chk(ACU_OFF_CHARGER, 24'h00007f);
        chk("charger pins", 24'h00007f, chg_pins);
    endtask : t_charger

    task automatic t_device;
        // Device clears the restart bit in the cycle right after the host set it
        wr_reg(ACU_OFF_CHARGER, 24'h182000);
        dev_restart_clr = 1'b1;
        chk("charger pins", 24'h18207f, chg_pins);
        @(negedge clock);
        dev_restart_clr = 1'b0;
        rd_chk(ACU_OFF_CHARGER, 24'h08207f);
        dev_pulse(1'b1, 1'b1, 1'b1, 1'b1);
        rd_chk(ACU_OFF_CHARGER, 24'h00004f);
        chk("charger pins", 24'h00004f, chg_pins);
    endtask : t_device

    task automatic t_usb;
        wr_reg(ACU_OFF_USB, 24'hffffff);
        rd_chk(ACU_OFF_USB, 24'h400040);
        chk("usb pins", 24'h000003, {22'h0, usb_pins});
        wr_reg(ACU_OFF_USB, 24'h000000);
        rd_chk(ACU_OFF_USB, 24'h000000);
    endtask : t_usb

    // Read-only places and an unmapped index must shrug off writes
    task automatic t_results;
        @(negedge clock);
        result_valid = 1'b1;
        // Read in the cycle right after the capture, while the live input has moved on
        @(negedge clock);
        result_valid = 1'b0;
        result_one   = 10'h000;
        reg_addr     = ACU_OFF_RESULTS;
        reg_rd       = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        chk("results at once", {10'h25a, 2'h0, 10'h3a5, 2'h0}, reg_rdata_reg);
        rd_chk(ACU_OFF_RESULTS, {10'h25a, 2'h0, 10'h3a5, 2'h0});
        wr_reg(ACU_OFF_RESULTS, 24'hffffff);
        rd_chk(ACU_OFF_RESULTS, {10'h25a, 2'h0, 10'h3a5, 2'h0});
        wr_reg(ACU_OFF_GEN_ID, 24'hffffff);
        rd_chk(ACU_OFF_GEN_ID, {15'h0, GEN_ID, 6'h00});
        wr_reg(6'h00, 24'hffffff);
        rd_chk(6'h00, 24'h000000);
    endtask : t_results

    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("Checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (10) @(negedge clock);
        srst = 1'b0;
        t_reset();
        t_charger();
        t_device();
        t_usb();
        t_results();
        complete_run();
    end

    // The whole sequence needs well under 200 cycles
    initial begin
        repeat (2000) @(posedge clock);
        bad_count++;
        complete_run();
    end
endmodule : tb_top
